// ==== dv/storage_model.sv ====
// storage partner: byte array answering doubleword fetches in order
// assumes one-cycle request pulses; answers alternate prompt and slow
`timescale 1ns/1ps
module storage_model
   import trt_pkg::*;
(
   input wire logic        clk,     // clock
   input wire logic        rst_n,   // reset
   input wire mem_req_type mem_req, // fetch request
   output mem_rsp_type     mem_rsp  // doubleword return
);
   logic [7:0]  mem [0:1023];
   logic [23:0] pend_q [$];
   logic [1:0]  gap_reg;
   logic        slow_reg;
   function automatic logic [63:0] dword(input logic [23:0] a);
      logic [63:0] d;
      for (int i = 0; i < 8; i++) d[63-8*i -: 8] = mem[{a[9:3], 3'(i)}];
      return d;
   endfunction : dword
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q.delete();
         mem_rsp  <= '0;
         gap_reg  <= 2'h0;
         slow_reg <= 1'b0;
      end else begin
         if (mem_req.req) pend_q.push_back(mem_req.addr);
         mem_rsp.valid <= 1'b0;
         // released bus must not keep showing the last word
         mem_rsp.data  <= ~mem_rsp.data;
         if (gap_reg != 2'h0) gap_reg <= gap_reg - 2'h1;
         else if (pend_q.size() > 0) begin
            mem_rsp  <= {1'b1, dword(pend_q.pop_front())};
            slow_reg <= ~slow_reg;
            gap_reg  <= slow_reg ? 2'h3 : 2'h0;
         end
      end
   end
endmodule : storage_model

// ==== dv/translate_test_sequencer_tb.sv ====
// self-checking bench for the translate-and-test sequencer
// assumes arguments below 0x200 in storage and the table at 0x200
`timescale 1ns/1ps
module translate_test_sequencer_tb;
   import trt_pkg::*;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [23:0] d, n;
   mem_req_type mem_req;
   mem_rsp_type mem_rsp;
   int          errors, num_checks, seed, cycles;
   int          dd [5] = '{5, 5, 0, 8, 7};
   int          ll [5] = '{11, 11, 0, 9, 4};
   int          hh [5] = '{-1, 6, 0, 9, 1};
   translate_test_sequencer u_translate_test_sequencer (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .mem_req(mem_req), .mem_rsp(mem_rsp));
   storage_model u_storage_model (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_rsp(mem_rsp));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         errors++;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check
   task automatic axi_write(input logic [11:0] a, input logic [31:0] x, output logic [1:0] resp);
      logic aw_left, w_left;
      @(posedge clk);
      aw_left = 1'b1;
      w_left = 1'b1;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= x;
      wvalid <= 1'b1;
      while (aw_left || w_left) begin
         @(posedge clk);
         if (aw_left && awready) begin
            aw_left = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_left && wready) begin
            w_left = 1'b0;
            wvalid <= 1'b0;
         end
      end
      // late bready so the response must wait for us
      while (!bvalid) @(posedge clk);
      bready <= 1'b1;
      @(posedge clk);
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [11:0] a, output logic [31:0] x, output logic [1:0] resp);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b1;
      @(posedge clk);
      x = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_read
   // scan of the argument bytes gives {cc, argument address, function byte}
   function automatic logic [33:0] expect_op(input logic [23:0] a, input logic [23:0] len);
      logic [7:0] f;
      for (int i = 0; i <= len; i++) begin
         f = u_storage_model.mem[10'(24'h200 + u_storage_model.mem[10'(a + i)])];
         if (f != 8'h0) return {(i == len) ? cc_last : cc_early, 24'(a + i), f};
      end
      return {cc_all_zero, 24'h0, 8'h0};
   endfunction : expect_op
   task automatic run_op(input logic [23:0] a, input logic [23:0] len);
      logic [31:0] g [4];
      logic [33:0] e;
      int k;
      for (k = 0; k < 4; k++) g[k] = $random(seed);
      axi_write(length_offset, {8'h0, len}, r);
      axi_write(dest_addr_offset, {8'h0, a}, r);
      axi_write(table_offset, 32'h200, r);
      axi_write(gr1_offset, g[0], r);
      axi_write(gr2_offset, g[1], r);
      axi_write(gr1_high_offset, g[2], r);
      axi_write(gr2_high_offset, g[3], r);
      e = expect_op(a, len);
      axi_write(ctrl_offset, 32'h1, r);
      if (len > 3) axi_write(gr1_high_offset, ~g[2], r);
      k = 0;
      do begin
         axi_read(status_offset, v, r);
         k++;
      end while ((v[stat_busy_bit] !== 1'b0 || v[stat_done_bit] !== 1'b1) && k < 500);
      check(v & 32'h2f, {26'h0, e[7:0] != 8'h0, 1'b0, e[33:32], 2'b10}, "status");
      axi_read(gr1_offset, v, r);
      check(v, (e[33:32] == cc_all_zero) ? g[0] : {g[0][31:24], e[31:8]}, "gr1");
      axi_read(gr2_offset, v, r);
      check(v, (e[33:32] == cc_all_zero) ? g[1] : {g[1][31:8], e[7:0]}, "gr2");
      axi_read(gr1_high_offset, v, r);
      check(v, g[2], "gr1 high");
      axi_read(gr2_high_offset, v, r);
      check(v, g[3], "gr2 high");
   endtask : run_op
   initial begin
      seed = 12;
      errors = 0;
      num_checks = 0;
      cycles = 0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      rst_n = 1'b0;
      for (int i = 0; i < 512; i++) u_storage_model.mem[i] = 8'($random(seed));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      axi_write(12'h024, 32'h1, r);
      check({30'h0, r}, {30'h0, resp_slverr}, "unmapped write");
      axi_read(12'h024, v, r);
      check({r, v[29:0]}, {resp_slverr, 30'h0}, "unmapped read");
      for (int k = 0; k < 17; k++) begin
         d = (k < 5) ? 24'(dd[k]) : 24'($random(seed) & 255);
         n = (k < 5) ? 24'(ll[k]) : 24'($random(seed) & 31);
         for (int i = 0; i < 256; i++)
            u_storage_model.mem[512+i] = (k < 5 || ($random(seed) & 15)) ? 8'h0 : 8'($random(seed) | 1);
         if (k < 5 && hh[k] >= 0) u_storage_model.mem[512 + u_storage_model.mem[d + hh[k]]] = 8'h5a;
         run_op(d, n);
      end
      finish_test();
   end
endmodule : translate_test_sequencer_tb

// ==== dv/trt_port_monitor.sv ====
// port checker for the translate-and-test sequencer
// assumes it is bound onto every sequencer instance
`timescale 1ns/1ps
module trt_port_monitor
   import trt_pkg::*;
(
   input wire logic        clk,           // clock
   input wire logic        rst_n,         // reset
   input wire logic        s_axi_awvalid, // aw valid
   input wire logic        s_axi_awready, // aw ready
   input wire logic        s_axi_wready,  // w ready
   input wire logic [1:0]  s_axi_bresp,   // b resp
   input wire logic        s_axi_bvalid,  // b valid
   input wire logic        s_axi_bready,  // b ready
   input wire logic [11:0] s_axi_araddr,  // ar addr
   input wire logic        s_axi_arvalid, // ar valid
   input wire logic        s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata,   // r data
   input wire logic [1:0]  s_axi_rresp,   // r resp
   input wire logic        s_axi_rvalid,  // r valid
   input wire logic        s_axi_rready,  // r ready
   input wire mem_req_type mem_req        // fetch request
);
   default clocking mc @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)) else $error("read response dropped");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while response pending");
   a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > gr2_high_offset
      |=> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   a_mapped_ok: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= gr2_high_offset
      && s_axi_araddr[1:0] == 2'b00 |=> s_axi_rresp == resp_okay) else $error("mapped read refused");
   c_fetch: cover property (mem_req.req);
   c_unmapped: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr > gr2_high_offset);
   c_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : trt_port_monitor
bind translate_test_sequencer trt_port_monitor u_trt_port_monitor (.clk(clk), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .mem_req(mem_req));

// ==== src/translate_test_sequencer.sv ====
// translate-and-test microsequencer with axi4-lite control registers
// assumes main storage answers each fetch request with one doubleword pulse, in order,
// and that software loads length, addresses and general registers before start
//
// Summary of operation
// - test selected table byte, keep copy saved
// - set word-exhausted when source counter at last byte (7)
// - dest counter to 3, source counter advances
// - nonzero table byte enters marking sequence
// - zero byte, zero length: end operation
// - continuing: decrement length, bump destination address
// - word exhausted branches to destination fetch
// - load next argument, dest counter from ic
// - fetched table byte becomes byte under test
// - no table word fetched after counter wrap
// - clear flags, restore table base address
// - fetch destination doubleword into source pair
// - select byte 0, request its table byte
// - then continue at argument address generation
// - nonzero byte clears pending flag on marking
// - clear lsa field, read general register one
// - keep high byte, insert destination address
// - step lsa twice, insert function byte
// - nonzero saved byte sets nonzero-function flag
// - end sequence derives condition code
// - cc 0 all zero, 1 early, 2 last
// - pending flag marks fetched untested byte
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module translate_test_sequencer
   import trt_pkg::*;
#(
   parameter int addr_width = 24                 // storage address width
) (
   input  wire logic        clk,                 // 100 MHz clock
   input  wire logic        rst_n,               // async reset, active low
   input  wire logic [11:0] s_axi_awaddr,        // write address
   input  wire logic        s_axi_awvalid,       // write address valid
   output logic             s_axi_awready,       // write address ready
   input  wire logic [31:0] s_axi_wdata,         // write data
   input  wire logic [3:0]  s_axi_wstrb,         // write strobes
   input  wire logic        s_axi_wvalid,        // write data valid
   output logic             s_axi_wready,        // write data ready
   output logic [1:0]       s_axi_bresp,         // write response
   output logic             s_axi_bvalid,        // write response valid
   input  wire logic        s_axi_bready,        // write response ready
   input  wire logic [11:0] s_axi_araddr,        // read address
   input  wire logic        s_axi_arvalid,       // read address valid
   output logic             s_axi_arready,       // read address ready
   output logic [31:0]      s_axi_rdata,         // read data
   output logic [1:0]       s_axi_rresp,         // read response
   output logic             s_axi_rvalid,        // read data valid
   input  wire logic        s_axi_rready,        // read data ready
   output mem_req_type      mem_req,             // storage fetch request pulse
   input  wire mem_rsp_type mem_rsp              // storage doubleword return
);
   seq_state_type state_reg;
   logic [63:0]   source_register_pair;          // destination doubleword being scanned
   logic [63:0]   working_register_pair;         // s and t halves
   logic [2:0]    source_byte_counter;
   logic [2:0]    dest_byte_counter;
   logic [23:0]   length_counter;
   logic [23:0]   instruction_counter;
   logic [23:0]   dest_addr_reg;
   logic [7:0]    byte_save_reg;
   logic [7:0]    current_argument_byte;         // argument whose table byte is in flight
   logic [7:0]    test_argument_byte;            // argument of byte under test
   logic [7:0]    local_storage_address;
   logic [63:0]   general_register_one;
   logic [63:0]   general_register_two;
   logic          pending_reg;
   logic          word_exhausted_reg;
   logic          nonzero_func_reg;
   logic          done_reg;
   logic [1:0]    condition_code;
   logic          start_pulse;
   logic [7:0]    table_byte;
   logic          aw_held, w_held;
   logic [11:0]   aw_addr_reg;
   logic [31:0]   w_data_reg;
   logic [3:0]    w_strb_reg;
   logic          wr_fire;

   function automatic logic [7:0] pick_byte(input logic [63:0] dw, input logic [2:0] idx);
      pick_byte = dw[8'(63 - 8 * idx) -: 8];
   endfunction : pick_byte

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : merge

   // serial adder path: the table byte is taken from the returned doubleword
   assign table_byte = pick_byte(mem_rsp.data, instruction_counter[2:0]);

   // axi write channel: address and data taken in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr_reg  <= 12'h000;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_held     <= !wr_fire;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_held     <= !wr_fire;
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   logic [11:0] wa;
   logic [31:0] wd;
   logic [3:0]  ws;
   logic        wr_ok;
   assign wa = aw_held ? aw_addr_reg : s_axi_awaddr;
   assign wd = w_held ? w_data_reg : s_axi_wdata;
   assign ws = w_held ? w_strb_reg : s_axi_wstrb;
   assign wr_ok = wa == ctrl_offset || wa == length_offset || wa == dest_addr_offset ||
                  wa == table_offset || wa == gr1_offset || wa == gr2_offset ||
                  wa == gr1_high_offset || wa == gr2_high_offset;
   assign start_pulse = wr_fire && wa == ctrl_offset && ws[0] && wd[ctrl_start_bit] &&
                        state_reg == st_idle;

   // bresp latched with the write; unmapped addresses give slverr
   logic bresp_next;
   assign bresp_next = wr_ok;

   // read channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= resp_okay;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= resp_okay;
         case (s_axi_araddr)
            ctrl_offset:      s_axi_rdata <= 32'h0000_0000;
            status_offset:    s_axi_rdata <= {25'h0, word_exhausted_reg, nonzero_func_reg, pending_reg,
                                              condition_code, done_reg, state_reg != st_idle};
            length_offset:    s_axi_rdata <= {8'h00, length_counter};
            dest_addr_offset: s_axi_rdata <= {8'h00, dest_addr_reg};
            table_offset:     s_axi_rdata <= {8'h00, instruction_counter};
            gr1_offset:       s_axi_rdata <= general_register_one[31:0];
            gr2_offset:       s_axi_rdata <= general_register_two[31:0];
            gr1_high_offset:  s_axi_rdata <= general_register_one[63:32];
            gr2_high_offset:  s_axi_rdata <= general_register_two[63:32];
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= resp_slverr;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // sequencer and datapath; software writes only land while idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg             <= st_idle;
         source_register_pair  <= 64'h0;
         working_register_pair <= 64'h0;
         source_byte_counter   <= 3'h0;
         dest_byte_counter     <= 3'h0;
         length_counter        <= 24'h0;
         instruction_counter   <= 24'h0;
         dest_addr_reg         <= 24'h0;
         byte_save_reg         <= 8'h00;
         current_argument_byte <= 8'h00;
         test_argument_byte    <= 8'h00;
         local_storage_address <= 8'h00;
         general_register_one  <= 64'h0;
         general_register_two  <= 64'h0;
         pending_reg           <= 1'b0;
         word_exhausted_reg    <= 1'b0;
         nonzero_func_reg      <= 1'b0;
         done_reg              <= 1'b0;
         condition_code        <= cc_all_zero;
         mem_req               <= '0;
         s_axi_bresp           <= resp_okay;
      end else begin
         mem_req.req <= 1'b0;
         if (wr_fire) begin
            s_axi_bresp <= bresp_next ? resp_okay : resp_slverr;
            if (state_reg == st_idle) begin
               case (wa)
                  length_offset:    length_counter <= 24'(merge({8'h00, length_counter}, wd, ws));
                  dest_addr_offset: dest_addr_reg <= 24'(merge({8'h00, dest_addr_reg}, wd, ws));
                  table_offset:     instruction_counter <= 24'(merge({8'h00, instruction_counter}, wd, ws));
                  gr1_offset:       general_register_one[31:0] <= merge(general_register_one[31:0], wd, ws);
                  gr2_offset:       general_register_two[31:0] <= merge(general_register_two[31:0], wd, ws);
                  gr1_high_offset:  general_register_one[63:32] <= merge(general_register_one[63:32], wd, ws);
                  gr2_high_offset:  general_register_two[63:32] <= merge(general_register_two[63:32], wd, ws);
                  default: ;
               endcase
            end
         end
         case (state_reg)
            st_idle: if (start_pulse) begin
               done_reg         <= 1'b0;
               nonzero_func_reg <= 1'b0;
               pending_reg      <= 1'b0;
               word_exhausted_reg <= 1'b0;
               source_byte_counter <= dest_addr_reg[2:0];
               mem_req <= '{req: 1'b1, addr: {dest_addr_reg[23:3], 3'h0}};
               state_reg <= st_first_wait;
            end
            st_first_fetch: state_reg <= st_first_wait;
            st_first_wait: if (mem_rsp.valid) begin
               source_register_pair <= mem_rsp.data;
               current_argument_byte <= pick_byte(mem_rsp.data, source_byte_counter);
               working_register_pair[39:32] <= pick_byte(mem_rsp.data, source_byte_counter);
               instruction_counter <= instruction_counter + 24'(pick_byte(mem_rsp.data, source_byte_counter));
               mem_req <= '{req: 1'b1, addr: instruction_counter +
                            24'(pick_byte(mem_rsp.data, source_byte_counter))};
               state_reg <= st_addr_gen;
            end
            st_addr_gen: begin
               // argument address generation for the byte one ahead of the one under test
               source_byte_counter <= source_byte_counter + 3'h1;
               test_argument_byte  <= current_argument_byte;
               current_argument_byte <= pick_byte(source_register_pair, source_byte_counter + 3'h1);
               pending_reg <= 1'b1;
               dest_byte_counter <= instruction_counter[2:0];
               word_exhausted_reg <= (source_byte_counter == last_byte_idx);
               state_reg <= st_ingate;
            end
            st_ingate: if (mem_rsp.valid) begin
               // table word holding the byte under test arrives
               byte_save_reg <= table_byte;
               instruction_counter <= instruction_counter - 24'(test_argument_byte);
               if (length_counter != 24'h0 && !word_exhausted_reg) begin
                  instruction_counter <= instruction_counter - 24'(test_argument_byte) +
                                         24'(current_argument_byte);
                  mem_req <= '{req: 1'b1, addr: instruction_counter - 24'(test_argument_byte) +
                               24'(current_argument_byte)};
               end
               state_reg <= st_test;
            end
            st_test: begin
               dest_byte_counter <= dest_cnt_test;
               if (byte_save_reg != 8'h00) begin
                  pending_reg <= 1'b0;
                  local_storage_address <= 8'h00;
                  state_reg <= st_mark_gr1;
               end else if (length_counter == 24'h0) begin
                  state_reg <= st_end_op;
               end else begin
                  length_counter <= length_counter - 24'h1;
                  dest_addr_reg  <= dest_addr_reg + 24'h1;
                  if (word_exhausted_reg) begin
                     // no table request was made for the wrapped byte
                     state_reg <= st_dest_fetch;
                  end else begin
                     working_register_pair[39:32] <= current_argument_byte;
                     dest_byte_counter <= instruction_counter[2:0];
                     test_argument_byte <= current_argument_byte;
                     current_argument_byte <= pick_byte(source_register_pair, source_byte_counter + 3'h1);
                     source_byte_counter <= source_byte_counter + 3'h1;
                     word_exhausted_reg <= (source_byte_counter == last_byte_idx);
                     state_reg <= st_ingate;
                  end
               end
            end
            st_dest_fetch: begin
               pending_reg        <= 1'b0;
               word_exhausted_reg <= 1'b0;
               mem_req <= '{req: 1'b1, addr: {dest_addr_reg[23:3], 3'h0}};
               state_reg <= st_dest_wait;
            end
            st_dest_wait: if (mem_rsp.valid) begin
               source_register_pair <= mem_rsp.data;
               source_byte_counter  <= 3'h0;
               current_argument_byte <= pick_byte(mem_rsp.data, 3'h0);
               working_register_pair[39:32] <= pick_byte(mem_rsp.data, 3'h0);
               instruction_counter <= instruction_counter + 24'(pick_byte(mem_rsp.data, 3'h0));
               mem_req <= '{req: 1'b1, addr: instruction_counter + 24'(pick_byte(mem_rsp.data, 3'h0))};
               state_reg <= st_addr_gen;
            end
            st_discard: state_reg <= st_addr_gen;
            st_mark_gr1: begin
               // high byte kept, argument address in low 24 bits
               dest_byte_counter <= dest_cnt_mark1;
               general_register_one <= {general_register_one[63:32], general_register_one[31:24],
                                        dest_addr_reg};
               local_storage_address <= local_storage_address + lsa_gr1_step + lsa_gr1_step;
               state_reg <= st_mark_gr2;
            end
            st_mark_gr2: begin
               dest_byte_counter <= dest_cnt_mark2;
               general_register_two[7:0] <= byte_save_reg;
               nonzero_func_reg <= byte_save_reg != 8'h00;
               state_reg <= st_end_op;
            end
            st_end_op: begin
               // early exit leaves length nonzero
               if (!nonzero_func_reg) begin
                  condition_code <= cc_all_zero;
               end else if (length_counter != 24'h0) begin
                  condition_code <= cc_early;
               end else begin
                  condition_code <= cc_last;
               end
               done_reg  <= 1'b1;
               state_reg <= st_idle;
            end
            default: state_reg <= st_idle;
         endcase
      end
   end
endmodule : translate_test_sequencer

// ==== src/trt_pkg.sv ====
// constants and carrier types for the translate-and-test microsequencer
// assumes one 100 MHz clock and single-word register access over axi4-lite
package trt_pkg;
   localparam logic [11:0] ctrl_offset      = 12'h000; // w: bit0 start (self clearing)
   localparam logic [11:0] status_offset    = 12'h004; // r: busy, done, cc, flags
   localparam logic [11:0] length_offset    = 12'h008; // rw: length counter
   localparam logic [11:0] dest_addr_offset = 12'h00c; // rw: destination address
   localparam logic [11:0] table_offset     = 12'h010; // rw: instruction counter (table base)
   localparam logic [11:0] gr1_offset       = 12'h014; // rw: general register one
   localparam logic [11:0] gr2_offset       = 12'h018; // rw: general register two
   localparam logic [11:0] gr1_high_offset  = 12'h01c; // rw: general register one high
   localparam logic [11:0] gr2_high_offset  = 12'h020; // rw: general register two high
   localparam int          ctrl_start_bit   = 0;
   localparam int          stat_busy_bit    = 0;
   localparam int          stat_done_bit    = 1;
   localparam int          stat_cc_lsb      = 2;
   localparam int          stat_pend_bit    = 4;
   localparam int          stat_nz_bit      = 5;
   localparam int          stat_wex_bit     = 6;
   localparam logic [2:0]  dest_cnt_test    = 3'h3;
   localparam logic [2:0]  dest_cnt_mark1   = 3'h4;
   localparam logic [2:0]  dest_cnt_mark2   = 3'h7;
   localparam logic [2:0]  last_byte_idx    = 3'h7;
   localparam logic [7:0]  lsa_gr1_step     = 8'h01;
   localparam logic [1:0]  resp_okay        = 2'b00;
   localparam logic [1:0]  resp_slverr      = 2'b10;
   localparam logic [1:0]  cc_all_zero      = 2'h0;
   localparam logic [1:0]  cc_early         = 2'h1;
   localparam logic [1:0]  cc_last          = 2'h2;

   typedef enum {
      st_idle, st_first_fetch, st_first_wait, st_addr_gen, st_ingate, st_test,
      st_dest_fetch, st_dest_wait, st_discard, st_mark_gr1, st_mark_gr2, st_end_op
   } seq_state_type;

   typedef struct packed {
      logic        req;
      logic [23:0] addr;
   } mem_req_type;

   typedef struct packed {
      logic        valid;
      logic [63:0] data;
   } mem_rsp_type;
endpackage : trt_pkg
